// File: asd_pkg.sv
// Package of constants and types for the arithmetic and shift datapath
package asd_pkg;
  localparam int DATA_W = 16;
  localparam int BANK_N = 32;
  localparam int ADDR_W = 5;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [31:0] REG_BASE_ADDR = 32'h0000_0000;
  localparam logic [31:0] REG_OPCODE = 32'h0000_0000;
  localparam logic [31:0] REG_OPERAND = 32'h0000_0004;
  localparam logic [31:0] REG_RESULT = 32'h0000_0008;
  localparam logic [31:0] REG_FLAGS = 32'h0000_000c;
  localparam logic [31:0] REG_EXT = 32'h0000_0010;
  localparam int FLG_Z = 0;
  localparam int FLG_C = 1;
  localparam int FLG_S = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ASD_ADD = 4'h0, ASD_SUB = 4'h1, ASD_INC = 4'h2, ASD_DEC = 4'h3, ASD_CMP = 4'h4,
    ASD_AND = 4'h5, ASD_OR = 4'h6, ASD_INV = 4'h7, ASD_XOR = 4'h8, ASD_XNOR = 4'h9,
    ASD_PASS = 4'ha
  } asd_op_e;

  typedef enum logic [2:0] {
    ASD_SH_NONE = 3'h0, ASD_SH_SGL = 3'h1, ASD_SH_DBL = 3'h2, ASD_ROT_SGL = 3'h3, ASD_ROT_DBL = 3'h4
  } asd_shift_e;

  typedef enum logic [2:0] {
    ASD_FILL_Z = 3'h0, ASD_FILL_C = 3'h1, ASD_FILL_S = 3'h2, ASD_FILL_0 = 3'h3,
    ASD_FILL_1 = 3'h4, ASD_FILL_OWN = 3'h5, ASD_FILL_EXT = 3'h6, ASD_FILL_SER = 3'h7
  } asd_fill_e;

  typedef enum logic [1:0] {
    ASD_CIN_0 = 2'h0, ASD_CIN_1 = 2'h1, ASD_CIN_CARRY = 2'h2
  } asd_cin_e;

  // Opcode register layout
  localparam int OP_LSB = 0;
  localparam int SH_LSB = 4;
  localparam int FILL_LSB = 7;
  localparam int CIN_LSB = 10;
  localparam int DIR_BIT = 12;
  localparam int DST_Q_BIT = 13;
  localparam int IMM_BIT = 14;
  localparam int A_LSB = 16;
  localparam int B_LSB = 21;
  localparam int DST_LSB = 26;
  localparam int A_Q_BIT = 31;
endpackage

// File: asd_regbank.sv
// Register bank of 32 general registers, registered read ports
`timescale 1ns/10ps
module asd_regbank #(
  parameter int W = asd_pkg::DATA_W,
  parameter int N = asd_pkg::BANK_N,
  parameter int AW = asd_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [W-1:0] rdata_a,
  output logic [W-1:0] rdata_b
);
  logic [W-1:0] mem [N];

  // No reset: contents are defined only once written
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata_a <= (we && waddr == raddr_a) ? wdata : mem[raddr_a];
    rdata_b <= (we && waddr == raddr_b) ? wdata : mem[raddr_b];
  end
endmodule

// File: asd_datapath.sv
// Single-cycle 16-bit arithmetic, logic and shift datapath with AXI4-Lite control
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
// Overview of operation
// RULE_01: Each instruction computes and writes back in one clock cycle.
// RULE_02: Sequencer picks at least one operand from bank or extension register.
// RULE_03: Datapath runs without stalls from counters, host or program control.
// RULE_04: Arithmetic: add, subtract, increment, decrement, compare.
// RULE_05: Logic: AND, OR, invert, XOR, XNOR.
// RULE_06: Operation first, then shift its result, then write back.
// RULE_07: Single-precision shifts move one register by one bit.
// RULE_08: Double-precision shifts span a bank register joined to extension register.
// RULE_09: Each register end filled through its own eight-way selector.
// RULE_10: Right shift top fill: Z, C, S, 0, 1, own low, ext low, serial.
// RULE_11: Left shift bottom fill: Z, C, S, 0, 1, own high, ext high, serial.
// RULE_12: Single and double precision rotates, left or right.
// RULE_13: Carry-out kept for the next instruction's carry-in.
// RULE_14: Carry-in chosen from 0, 1 or previous carry-out.
// RULE_15: 16-bit wide, 32 bank registers plus the extension register.
// RULE_16: Zero flag on all-zero result, sign is top bit, carry is carry-out.
// RULE_17: Compare subtracts, updates flags, leaves destination unchanged.
module asd_datapath (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic SERIAL_RIGHT_FILL,
  input wire logic SERIAL_LEFT_FILL,
  input wire logic [31:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [31:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  output logic [asd_pkg::DATA_W-1:0] RESULT,
  output logic ZERO_FLAG,
  output logic CARRY_FLAG,
  output logic SIGN_FLAG
);
  import asd_pkg::*;

  localparam int W = DATA_W;

  // Reset release
  logic rst_s1_q, rst_n;
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Serial fill pins pass two flops
  logic [1:0] ser_s1_q, ser_s2_q;
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ser_s1_q <= 2'h0;
      ser_s2_q <= 2'h0;
    end
    else
    begin
      ser_s1_q <= {SERIAL_LEFT_FILL, SERIAL_RIGHT_FILL};
      ser_s2_q <= ser_s1_q;
    end
  end
  wire ser_right = ser_s2_q[0];
  wire ser_left = ser_s2_q[1];

  // AXI4-Lite write side: address and data taken in either order
  logic aw_got_q, w_got_q, bvalid_q, awready_q, wready_q;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;
  wire aw_hs = AWVALID && AWREADY;
  wire w_hs = WVALID && WREADY;
  wire aw_have = aw_got_q || aw_hs;
  wire w_have = w_got_q || w_hs;
  wire wr_fire = aw_have && w_have && !bvalid_q;
  wire b_hold = bvalid_q && !BREADY;
  wire [31:0] wr_addr = aw_got_q ? awaddr_q : AWADDR;
  wire [31:0] wr_data = w_got_q ? wdata_q : WDATA;
  wire [3:0] wr_strb = w_got_q ? wstrb_q : WSTRB;

  function automatic logic addr_known(input logic [31:0] a);
    addr_known = (a == REG_OPCODE) || (a == REG_OPERAND) || (a == REG_RESULT) ||
                 (a == REG_FLAGS) || (a == REG_EXT);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        m[i*8 +: 8] = nw[i*8 +: 8];
    merge = m;
  endfunction

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      BRESP <= RESP_OKAY;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
    end
    else
    begin
      if (aw_hs)
        awaddr_q <= AWADDR;
      if (w_hs)
      begin
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end
      aw_got_q <= wr_fire ? 1'b0 : aw_have;
      w_got_q <= wr_fire ? 1'b0 : w_have;
      // Readies computed one edge early so the ports leave flops
      awready_q <= !wr_fire && !aw_have && !b_hold;
      wready_q <= !wr_fire && !w_have && !b_hold;
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        BRESP <= addr_known(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (BREADY)
        bvalid_q <= 1'b0;
    end
  end
  assign AWREADY = awready_q;
  assign WREADY = wready_q;
  assign BVALID = bvalid_q;

  // Instruction and operand registers written by the sequencer over the bus
  logic [31:0] opcode_q, operand_q;
  wire wr_opc = wr_fire && wr_addr == REG_OPCODE;
  wire wr_opd = wr_fire && wr_addr == REG_OPERAND;

  // Decoded fields
  wire asd_op_e op = asd_op_e'(opcode_q[OP_LSB +: 4]);
  wire asd_shift_e shm = asd_shift_e'(opcode_q[SH_LSB +: 3]);
  wire asd_fill_e fill = asd_fill_e'(opcode_q[FILL_LSB +: 3]);
  wire asd_cin_e cin_sel = asd_cin_e'(opcode_q[CIN_LSB +: 2]);
  wire sh_left = opcode_q[DIR_BIT];
  wire dst_q = opcode_q[DST_Q_BIT];
  wire use_imm = opcode_q[IMM_BIT];
  wire a_is_q = opcode_q[A_Q_BIT];
  wire [ADDR_W-1:0] ra = opcode_q[A_LSB +: ADDR_W];
  wire [ADDR_W-1:0] rb = opcode_q[B_LSB +: ADDR_W];
  wire [ADDR_W-1:0] rd = opcode_q[DST_LSB +: ADDR_W];

  // Execute one cycle after the opcode write; reads settle in that cycle
  logic exec_q;
  logic [W-1:0] ext_q;
  logic zf_q, cf_q, sf_q;
  logic [W-1:0] bank_a, bank_b;

  wire bank_we;
  wire [W-1:0] bank_wdata;
  asd_regbank #(.W(W), .N(BANK_N), .AW(ADDR_W)) u_bank ( // RULE_15
    .clk(MCLK),
    .we(bank_we),
    .waddr(rd),
    .wdata(bank_wdata),
    .raddr_a(wr_opc ? wr_data[A_LSB +: ADDR_W] : ra),
    .raddr_b(wr_opc ? wr_data[B_LSB +: ADDR_W] : rb),
    .rdata_a(bank_a),
    .rdata_b(bank_b)
  );

  // Operand A is always internal; B is bank or external operand
  wire [W-1:0] opa = a_is_q ? ext_q : bank_a; // RULE_02
  wire [W-1:0] opb = use_imm ? operand_q[W-1:0] : bank_b;

  wire cin = (cin_sel == ASD_CIN_1) ? 1'b1 : (cin_sel == ASD_CIN_CARRY) ? cf_q : 1'b0; // RULE_14 RULE_13

  wire [W:0] sum_add = {1'b0, opa} + {1'b0, opb} + {{W{1'b0}}, cin};
  wire [W:0] sum_sub = {1'b0, opa} + {1'b0, ~opb} + {{W{1'b0}}, cin};
  wire [W:0] sum_inc = {1'b0, opa} + {{W{1'b0}}, 1'b1};
  wire [W:0] sum_dec = {1'b0, opa} + {1'b0, {W{1'b1}}};

  logic [W:0] alu;
  always_comb
  begin
    case (op)
      ASD_ADD: alu = sum_add; // RULE_04
      ASD_SUB, ASD_CMP: alu = sum_sub; // RULE_04 RULE_17
      ASD_INC: alu = sum_inc;
      ASD_DEC: alu = sum_dec;
      ASD_AND: alu = {1'b0, opa & opb}; // RULE_05
      ASD_OR: alu = {1'b0, opa | opb};
      ASD_INV: alu = {1'b0, ~opa};
      ASD_XOR: alu = {1'b0, opa ^ opb};
      ASD_XNOR: alu = {1'b0, ~(opa ^ opb)};
      ASD_PASS: alu = {1'b0, opb};
      default: alu = {1'b0, opa};
    endcase
  end
  wire [W-1:0] res = alu[W-1:0];

  // Fill selectors; own bit reads the ALU result, which is what is shifted
  function automatic logic fill_pick(input asd_fill_e f, input logic z, input logic c, input logic s,
                                     input logic own, input logic ext, input logic ser);
    case (f)
      ASD_FILL_Z: fill_pick = z;
      ASD_FILL_C: fill_pick = c;
      ASD_FILL_S: fill_pick = s;
      ASD_FILL_0: fill_pick = 1'b0;
      ASD_FILL_1: fill_pick = 1'b1;
      ASD_FILL_OWN: fill_pick = own;
      ASD_FILL_EXT: fill_pick = ext;
      ASD_FILL_SER: fill_pick = ser;
      default: fill_pick = 1'b0;
    endcase
  endfunction

  wire fill_top = fill_pick(fill, zf_q, cf_q, sf_q, res[0], ext_q[0], ser_right); // RULE_09 RULE_10
  wire fill_bot = fill_pick(fill, zf_q, cf_q, sf_q, res[W-1], ext_q[W-1], ser_left); // RULE_09 RULE_11

  // Shift after operation
  logic [W-1:0] sh_res, sh_ext;
  always_comb
  begin
    sh_res = res;
    sh_ext = ext_q;
    case (shm)
      ASD_SH_NONE: sh_res = res;
      ASD_SH_SGL: sh_res = sh_left ? {res[W-2:0], fill_bot} : {fill_top, res[W-1:1]}; // RULE_07 RULE_06
      ASD_SH_DBL: // RULE_08
      begin
        if (sh_left)
        begin
          sh_res = {res[W-2:0], ext_q[W-1]};
          sh_ext = {ext_q[W-2:0], fill_bot};
        end
        else
        begin
          sh_res = {fill_top, res[W-1:1]};
          sh_ext = {res[0], ext_q[W-1:1]};
        end
      end
      ASD_ROT_SGL: sh_res = sh_left ? {res[W-2:0], res[W-1]} : {res[0], res[W-1:1]}; // RULE_12
      ASD_ROT_DBL: // RULE_12
      begin
        if (sh_left)
        begin
          sh_res = {res[W-2:0], ext_q[W-1]};
          sh_ext = {ext_q[W-2:0], res[W-1]};
        end
        else
        begin
          sh_res = {ext_q[0], res[W-1:1]};
          sh_ext = {res[0], ext_q[W-1:1]};
        end
      end
      default: sh_res = res;
    endcase
  end

  wire is_cmp = (op == ASD_CMP);
  wire dbl = (shm == ASD_SH_DBL) || (shm == ASD_ROT_DBL);
  wire write_back = exec_q && !is_cmp; // RULE_17
  assign bank_we = write_back && !dst_q; // RULE_01
  assign bank_wdata = sh_res;
  wire ext_we = write_back && (dst_q || dbl);
  wire [W-1:0] ext_d = (dst_q && !dbl) ? sh_res : sh_ext;
  wire [W-1:0] flag_val = is_cmp ? res : sh_res;
  wire [31:0] ext_merged = merge({16'h0, ext_q}, wr_data, wr_strb);

  // Nothing outside this block can hold off execution
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opcode_q <= 32'h0;
      operand_q <= 32'h0;
      exec_q <= 1'b0;
    end
    else
    begin
      if (wr_opc)
        opcode_q <= merge(opcode_q, wr_data, wr_strb);
      if (wr_opd)
        operand_q <= merge(operand_q, wr_data, wr_strb);
      exec_q <= wr_opc; // RULE_03
    end
  end

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_q <= REG_RESET;
      zf_q <= 1'b0;
      cf_q <= 1'b0;
      sf_q <= 1'b0;
      RESULT <= REG_RESET;
    end
    else if (exec_q)
    begin
      if (ext_we)
        ext_q <= ext_d;
      zf_q <= (flag_val == '0); // RULE_16
      sf_q <= flag_val[W-1]; // RULE_16
      cf_q <= alu[W]; // RULE_13 RULE_16
      RESULT <= dst_q && !dbl ? ext_d : flag_val;
    end
    else if (wr_fire && wr_addr == REG_EXT)
      ext_q <= ext_merged[W-1:0];
  end
  assign ZERO_FLAG = zf_q;
  assign CARRY_FLAG = cf_q;
  assign SIGN_FLAG = sf_q;

  // Read side
  logic rvalid_q, arready_q;
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
      RDATA <= 32'h0;
      RRESP <= RESP_OKAY;
    end
    else if (ARVALID && ARREADY)
    begin
      rvalid_q <= 1'b1;
      arready_q <= 1'b0;
      RRESP <= addr_known(ARADDR) ? RESP_OKAY : RESP_SLVERR;
      case (ARADDR)
        REG_OPCODE: RDATA <= opcode_q;
        REG_OPERAND: RDATA <= operand_q;
        REG_RESULT: RDATA <= {16'h0, RESULT};
        REG_FLAGS: RDATA <= {29'h0, sf_q, cf_q, zf_q};
        REG_EXT: RDATA <= {16'h0, ext_q};
        default: RDATA <= 32'h0;
      endcase
    end
    else if (RREADY)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end
  assign ARREADY = arready_q;
  assign RVALID = rvalid_q;
endmodule

// File: asd_datapath_chk.sv
// Checker of handshake and flag relations at the datapath ports
`timescale 1ns/10ps
module asd_datapath_chk (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [asd_pkg::DATA_W-1:0] RESULT,
  input wire logic ZERO_FLAG,
  input wire logic CARRY_FLAG,
  input wire logic SIGN_FLAG
);
  import asd_pkg::*;
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!NRST);
  chk_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  chk_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  chk_r_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  chk_b_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |=> BVALID)
    else $error("write answer late");
  chk_ar_refuse: assert property (RVALID |-> !ARREADY)
    else $error("read taken while busy");
  chk_aw_refuse: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while busy");
  chk_zs_flags: assert property ($changed(RESULT) |-> ZERO_FLAG == (RESULT == 16'h0) && SIGN_FLAG == RESULT[15])
    else $error("zero or sign flag wrong");
  chk_flag_cause: assert property ($changed({RESULT, ZERO_FLAG, CARRY_FLAG, SIGN_FLAG}) |-> $past(BVALID))
    else $error("result moved without instruction");
endmodule
bind asd_datapath asd_datapath_chk asd_datapath_chk_i (.*);

// File: asd_fill_src.sv
// Model of the serial fill sources beside the datapath
`timescale 1ns/10ps
module asd_fill_src (
  input wire logic clk,
  input wire logic [1:0] lvl,
  output logic right_fill,
  output logic left_fill
);
  initial {right_fill, left_fill} = 2'h0;
  // Registered, so levels move only after an edge
  always @(posedge clk)
  begin
    right_fill <= lvl[1];
    left_fill <= lvl[0];
  end
endmodule

// File: asd_datapath_test.sv
// Self-checking bench for the arithmetic and shift datapath
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end
module asd_datapath_test;
  import asd_pkg::*;
  logic MCLK = 1'b0;
  logic NRST = 1'b0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0, RDATA, rdat;
  logic [3:0] WSTRB = 4'hf;
  logic [1:0] BRESP, RRESP, rsp;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, ZERO_FLAG, CARRY_FLAG, SIGN_FLAG;
  logic SERIAL_RIGHT_FILL, SERIAL_LEFT_FILL;
  logic [15:0] RESULT;
  logic [1:0] ser_lvl = 2'h3;
  int fail_count = 0;
  int total_checks = 0;
  asd_datapath asd_datapath_i (.*);
  asd_fill_src asd_fill_src_i (.clk(MCLK), .lvl(ser_lvl), .right_fill(SERIAL_RIGHT_FILL), .left_fill(SERIAL_LEFT_FILL));
  task automatic results;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [31:0] ad, input logic [31:0] d, input int st);
    int n;
    n = 0;
    @(posedge MCLK);
    AWADDR <= ad;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= (st == 0);
    do
    begin
      @(posedge MCLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      n++;
      if (n == st) BREADY <= 1'b1;
    end while (!(BVALID && BREADY) && n < 50);
    rsp = BRESP;
    BREADY <= 1'b0;
    if (n >= 50) fail_count++;
  endtask
  task automatic rd(input logic [31:0] ad, input int st);
    int n;
    n = 0;
    @(posedge MCLK);
    ARADDR <= ad;
    ARVALID <= 1'b1;
    RREADY <= (st == 0);
    do
    begin
      @(posedge MCLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      n++;
      if (n == st) RREADY <= 1'b1;
    end while (!(RVALID && RREADY) && n < 50);
    rdat = RDATA;
    rsp = RRESP;
    RREADY <= 1'b0;
    if (n >= 50) fail_count++;
  endtask
  function automatic logic [31:0] opc(input logic [3:0] o, input logic [2:0] sh, input logic [2:0] f,
    input logic [1:0] ci, input logic l, input logic im, input logic [4:0] a, input logic [4:0] b,
    input logic [4:0] d);
    opc = {1'b0, d, b, a, 1'b0, im, 1'b0, l, ci, f, sh, o};
  endfunction
  // Execution lands one edge after the write answer is raised
  task automatic ex(input logic [31:0] w);
    wr(REG_OPCODE, w, 0);
    repeat (2) @(posedge MCLK);
  endtask
  task automatic ld(input logic [4:0] r, input logic [15:0] v);
    wr(REG_OPERAND, {16'h0, v}, 0);
    ex(opc(ASD_PASS, ASD_SH_NONE, 3'h0, 2'h0, 1'b0, 1'b1, 5'h0, 5'h0, r));
  endtask
  // Mask bit 3 selects the result, bits 2..0 the flags S, C, Z
  task automatic ck(input logic [16:0] v, input logic [3:0] m);
    if (m[3])
      `CHK("result", v[15:0], RESULT)
    `CHK("flags", {v[15], v[16], v[15:0] == 16'h0} & m[2:0], {SIGN_FLAG, CARRY_FLAG, ZERO_FLAG} & m[2:0])
  endtask
  task automatic t_bus;
    rd(REG_RESULT, 2);
    `CHK("result reset", 32'h0, rdat)
    rd(32'h40, 1);
    `CHK("read err", RESP_SLVERR, rsp)
    wr(32'h44, 32'h0, 2);
    `CHK("write err", RESP_SLVERR, rsp)
    wr(REG_EXT, 32'h8001, 0);
    rd(REG_EXT, 0);
    `CHK("ext", 32'h8001, rdat)
    ld(5'h1, 16'h8001);
    ld(5'h2, 16'h0003);
    ld(5'h3, 16'h0000);
    ld(5'h4, 16'hc002);
  endtask
  task automatic t_ops;
    logic [16:0] ev[10] = '{17'h08004, 17'h17ffe, 17'h08002, 17'h18000, 17'h0,
      17'h00001, 17'h08003, 17'h07ffe, 17'h08002, 17'h07ffd};
    for (int i = 0; i < 10; i++)
    begin
      if (i == 4) continue;
      ex(opc(4'(i), ASD_SH_NONE, 3'h0, {1'b0, i == 1}, 1'b0, 1'b0, 5'h1, 5'h2, 5'h6));
      ck(ev[i], 4'hf);
    end
    ex(opc(ASD_SUB, ASD_SH_NONE, 3'h0, ASD_CIN_1, 1'b0, 1'b0, 5'h1, 5'h2, 5'h6));
    ex(opc(ASD_ADD, ASD_SH_NONE, 3'h0, ASD_CIN_CARRY, 1'b0, 1'b0, 5'h3, 5'h3, 5'h6));
    ck(17'h00001, 4'hf);
    ex(opc(ASD_ADD, ASD_SH_NONE, 3'h0, ASD_CIN_CARRY, 1'b0, 1'b0, 5'h3, 5'h3, 5'h6));
    ck(17'h00000, 4'hf);
  endtask
  task automatic t_cmp;
    ld(5'h6, 16'h1234);
    ex(opc(ASD_CMP, ASD_SH_NONE, 3'h0, ASD_CIN_1, 1'b0, 1'b0, 5'h1, 5'h1, 5'h6));
    ck(17'h10000, 4'h7);
    rd(REG_FLAGS, 0);
    `CHK("flag reg", 32'h3, rdat)
    ex(opc(ASD_PASS, ASD_SH_NONE, 3'h0, 2'h0, 1'b0, 1'b0, 5'h0, 5'h6, 5'h7));
    ck(17'h01234, 4'hd);
  endtask
  // Fill tables assume flags Z0 C1 S0, own c002, extension 8001, serial 1
  task automatic t_shift;
    logic [7:0] fr = 8'hd2;
    logic [7:0] fl = 8'hf2;
    logic [15:0] lv = 16'hc002;
    logic [15:0] e;
    ex(opc(ASD_ADD, ASD_SH_SGL, ASD_FILL_0, 2'h0, 1'b1, 1'b0, 5'h1, 5'h2, 5'h7));
    ck(17'h00008, 4'hd);
    for (int f = 0; f < 16; f++)
    begin
      ex(opc(ASD_SUB, ASD_SH_NONE, 3'h0, ASD_CIN_1, 1'b0, 1'b0, 5'h1, 5'h2, 5'h7));
      ex(opc(ASD_PASS, ASD_SH_SGL, 3'(f), 2'h0, f[3], 1'b0, 5'h0, 5'h4, 5'h8));
      e = f[3] ? {lv[14:0], fl[f[2:0]]} : {fr[f[2:0]], lv[15:1]};
      ck({1'b0, e}, 4'hd);
    end
    // Pins now differ, so a swap of the two fill inputs shows
    ser_lvl <= 2'h1;
    repeat (4) @(posedge MCLK);
    ex(opc(ASD_PASS, ASD_SH_SGL, ASD_FILL_SER, 2'h0, 1'b0, 1'b0, 5'h0, 5'h4, 5'h8));
    ck({2'b0, lv[15:1]}, 4'hd);
    ex(opc(ASD_PASS, ASD_SH_SGL, ASD_FILL_SER, 2'h0, 1'b1, 1'b0, 5'h0, 5'h4, 5'h8));
    ck({1'b0, lv[14:0], 1'b1}, 4'hd);
  endtask
  task automatic t_dbl;
    logic [15:0] rv[6] = '{16'h6001, 16'h8005, 16'h6001, 16'h8005, 16'he001, 16'h8005};
    logic [15:0] xv[6] = '{16'h4000, 16'h0002, 16'h8001, 16'h8001, 16'h4000, 16'h0003};
    for (int i = 0; i < 6; i++)
    begin
      wr(REG_EXT, 32'h8001, 0);
      ex(opc(ASD_PASS, 3'(2 + i / 2), ASD_FILL_0, 2'h0, i[0], 1'b0, 5'h0, 5'h4, 5'h9));
      ck({1'b0, rv[i]}, 4'hd);
      rd(REG_EXT, 0);
      `CHK("ext", {16'h0, xv[i]}, rdat)
    end
  endtask
  initial
  begin
    forever #5 MCLK = ~MCLK;
  end
  initial
  begin
    repeat (6000) @(posedge MCLK);
    fail_count++;
    results();
  end
  initial
  begin
    repeat (16) @(posedge MCLK);
    NRST <= 1'b1;
    repeat (3) @(posedge MCLK);
    t_bus();
    t_ops();
    t_cmp();
    t_shift();
    t_dbl();
    results();
  end
endmodule
